// ---- logic/sli_pkg.sv ----
// Purpose: shared constants and carriers of the status lamp indicator
// Assumes: 20 MHz reference clock, synchronous active-high reset
// Notes:   times are in ms, counts are derived from them
`default_nettype none
package sli_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned BASE_TICK_MS = 100;
  localparam int unsigned BASE_TICK_CYC = (CLK_HZ / 1000) * BASE_TICK_MS;
  // blink and flash timing, in ms and in base ticks
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned FLASH_ON_MS    = 200;
  localparam int unsigned FLASH_OFF_MS   = 200;
  localparam int unsigned FLASH_GAP_MS   = 1000;
  localparam logic [3:0] BLINK_HALF_TICKS = 4'(BLINK_HALF_MS / BASE_TICK_MS);
  localparam logic [3:0] FLASH_ON_TICKS   = 4'(FLASH_ON_MS / BASE_TICK_MS);
  localparam logic [3:0] FLASH_OFF_TICKS  = 4'(FLASH_OFF_MS / BASE_TICK_MS);
  localparam logic [3:0] FLASH_GAP_TICKS  = 4'(FLASH_GAP_MS / BASE_TICK_MS);
  localparam logic [3:0] INFO_FLASHES     = 4'h2;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
  // control fields
  localparam int unsigned CTRL_DUR_LSB = 0;   // interlock duration, ticks
  localparam int unsigned CTRL_DUR_W   = 8;
  localparam int unsigned CTRL_EN_BIT  = 8;   // lamp enable
  localparam logic [31:0] CTRL_RST     = 32'h0000_010A;
  localparam logic [4:0]  MASK_RST     = 5'h00;
  // interrupt event bits
  localparam int unsigned IRQ_W          = 5;
  localparam int unsigned IRQ_ALARM      = 0;
  localparam int unsigned IRQ_PWR_REMOVE = 1;
  localparam int unsigned IRQ_DUP_IP     = 2;
  localparam int unsigned IRQ_TIMEOUT    = 3;
  localparam int unsigned IRQ_DIAG_DONE  = 4;
  // conditions from the driver core
  typedef struct packed {
    logic       ctrl_power;          // control power present
    logic       alarm;               // any alarm active
    logic       alarm_fatal;         // alarm not resettable remotely
    logic [3:0] alarm_code;          // flash count of the alarm
    logic       power_removal;       // power removal active
    logic       torque_off_clear;    // clear input after removal
    logic       info;                // information condition
    logic       support_op;          // teaching or remote operation
    logic       interlock_released;  // one-cycle pulse
    logic       origin_busy;         // origin button function running
    logic       sim_mode;            // driver simulation mode
    logic       cfg_invalid;         // communication setting invalid
    logic       dup_ip;              // duplicate address seen
    logic       self_diag;           // power-on self-diagnosis
    logic       online;
    logic       scanner_conn;
    logic       conn_timeout;
    logic       frame_activity;
  } sli_cond_t;
  // lamp drive, active high lit
  typedef struct packed {
    logic pa_green;
    logic pa_red;
    logic ms_green;
    logic ms_red;
    logic ns_green;
    logic ns_red;
    logic link;
  } sli_lamps_t;
  // one colour pair
  typedef struct packed {
    logic green;
    logic red;
  } sli_pair_t;
endpackage : sli_pkg
`default_nettype wire

// ---- logic/sli_tick_div.sv ----
// Purpose: base tick divider, one-cycle enable every CYCLES clocks
// Assumes: single clock, synchronous reset
// Notes:   first tick comes CYCLES clocks after reset release
`default_nettype none
module sli_tick_div #(
  parameter int unsigned CYCLES = 2_000_000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output var  logic o_tick
);
  localparam int unsigned CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;   // cycle counter
  logic [CW-1:0] cnt_d;
  logic          tick_q;  // registered pulse
  wire           wrap = (cnt_q == LAST);

  generate
    if (CYCLES < 2) begin : g_bad
      $error("sli_tick_div: CYCLES must be at least 2");
    end
  endgenerate

  assign cnt_d  = wrap ? '0 : cnt_q + 1'b1;
  assign o_tick = tick_q;

  // count and emit the pulse on wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= wrap;
    end
  end
endmodule : sli_tick_div
`default_nettype wire

// ---- logic/sli_top.sv ----
// Purpose: front-panel lamp logic with Avalon-MM registers and interrupt
// Assumes: condition inputs synchronous to i_ref_clk
// Notes:   one wait state on every bus access
`default_nettype none
module sli_top #(
  parameter int unsigned TICK_CYCLES = sli_pkg::BASE_TICK_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire sli_pkg::sli_cond_t i_cond,
  input  wire logic [3:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output var  logic [31:0]       o_avs_readdata,
  output var  logic              o_avs_waitrequest,
  output var  sli_pkg::sli_lamps_t o_lamps,
  output var  logic              o_irq
);
  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} sli_fl_t;
  typedef enum logic [1:0] {SM_GREEN, SM_RED, SM_BOTH, SM_DARK} sli_sim_t;

  generate
    if (TICK_CYCLES < 2) begin : g_bad
      $error("sli_top: TICK_CYCLES must be at least 2");
    end
  endgenerate

  // base tick
  logic tick;
  sli_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .o_tick    (tick)
  );

  // ---------------- bus slave ----------------
  logic [31:0] ctrl_q;        // control register
  logic [4:0]  irq_stat_q;    // sticky events
  logic [4:0]  irq_mask_q;    // interrupt enables
  logic [31:0] rdata_q;       // read data, stands when wait drops
  logic        wait_q;        // waitrequest, high unless answering
  logic [4:0]  irq_set;       // events this cycle
  logic [31:0] status_word;   // live state readback
  logic [31:0] rdata_d;
  wire         req     = i_avs_read | i_avs_write;
  wire         wr_go   = i_avs_write & ~wait_q;  // write takes effect
  wire         sel_ctl = (i_avs_address == sli_pkg::OFS_CTRL);
  wire         sel_sts = (i_avs_address == sli_pkg::OFS_STATUS);
  wire         sel_ist = (i_avs_address == sli_pkg::OFS_IRQ_STAT);
  wire         sel_msk = (i_avs_address == sli_pkg::OFS_IRQ_MASK);
  wire [4:0]   w1c     = (wr_go && sel_ist) ? i_avs_writedata[4:0] : 5'h0;
  // set wins over a simultaneous write-one clear
  wire [4:0]   irq_stat_d = (irq_stat_q & ~w1c) | irq_set;
  wire         lamp_en = ctrl_q[sli_pkg::CTRL_EN_BIT];
  wire [7:0]   il_dur  =
    ctrl_q[sli_pkg::CTRL_DUR_LSB +: sli_pkg::CTRL_DUR_W];

  // read mux, unmapped offsets read zero
  assign rdata_d = sel_ctl ? ctrl_q :
                   sel_sts ? status_word :
                   sel_ist ? {27'h0, irq_stat_q} :
                   sel_msk ? {27'h0, irq_mask_q} : 32'h0000_0000;

  // wait state and read capture
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // writable registers; writes to status and unmapped are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_q     <= sli_pkg::CTRL_RST;
      irq_mask_q <= sli_pkg::MASK_RST;
      irq_stat_q <= 5'h00;
    end else begin
      if (wr_go && sel_ctl) begin
        ctrl_q <= i_avs_writedata;
      end
      if (wr_go && sel_msk) begin
        irq_mask_q <= i_avs_writedata[4:0];
      end
      irq_stat_q <= irq_stat_d;
    end
  end

  // ---------------- event detection ----------------
  sli_pkg::sli_cond_t prev_q;  // last cycle's conditions
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= i_cond;
    end
  end
  assign irq_set[sli_pkg::IRQ_ALARM]      = i_cond.alarm & ~prev_q.alarm;
  assign irq_set[sli_pkg::IRQ_PWR_REMOVE] =
    i_cond.power_removal & ~prev_q.power_removal;
  assign irq_set[sli_pkg::IRQ_DUP_IP]     = i_cond.dup_ip & ~prev_q.dup_ip;
  assign irq_set[sli_pkg::IRQ_TIMEOUT]    =
    i_cond.conn_timeout & ~prev_q.conn_timeout;
  assign irq_set[sli_pkg::IRQ_DIAG_DONE]  =
    ~i_cond.self_diag & prev_q.self_diag;

  // ---------------- blink base, 500 ms halves ----------------
  logic [3:0] bl_cnt_q;   // ticks in current half
  logic       blink_q;    // 1 in the on half
  logic       fast_q;     // toggles each tick, traffic flicker
  wire        bl_wrap = tick && (bl_cnt_q == sli_pkg::BLINK_HALF_TICKS - 4'h1);
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bl_cnt_q <= 4'h0;
      blink_q  <= 1'b1;
      fast_q   <= 1'b0;
    end else if (tick) begin
      bl_cnt_q <= bl_wrap ? 4'h0 : bl_cnt_q + 4'h1;
      blink_q  <= bl_wrap ? ~blink_q : blink_q;
      fast_q   <= ~fast_q;
    end
  end

  // ---------------- simulation cycle ----------------
  sli_sim_t sim_q;  // advances every blink half
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_cond.sim_mode) begin
      sim_q <= SM_GREEN;
    end else if (bl_wrap) begin
      unique case (sim_q)
        SM_GREEN: sim_q <= SM_RED;
        SM_RED:   sim_q <= SM_BOTH;
        SM_BOTH:  sim_q <= SM_DARK;
        SM_DARK:  sim_q <= SM_GREEN;
      endcase
    end
  end

  // ---------------- counted flash sequencer ----------------
  // a burst of N flashes then a gap; the count is latched at burst start
  // so a code change mid-burst never produces a garbled count
  sli_fl_t    fl_q;
  logic [3:0] fl_tk_q;    // ticks in state
  logic [3:0] fl_n_q;     // flashes done
  logic [3:0] fl_tgt_q;   // flashes wanted
  logic [3:0] fl_want;
  logic [3:0] fl_lim;
  wire        code_nz = (i_cond.alarm_code != 4'h0);
  assign fl_want = i_cond.alarm ? (code_nz ? i_cond.alarm_code : 4'h1) :
                   (i_cond.info || i_cond.support_op) ?
                   sli_pkg::INFO_FLASHES : 4'h0;
  assign fl_lim  = (fl_q == FL_ON)  ? sli_pkg::FLASH_ON_TICKS :
                   (fl_q == FL_OFF) ? sli_pkg::FLASH_OFF_TICKS :
                   sli_pkg::FLASH_GAP_TICKS;
  wire fl_done = tick && (fl_tk_q == fl_lim - 4'h1);
  wire fl_lit  = (fl_q == FL_ON);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fl_q     <= FL_IDLE;
      fl_tk_q  <= 4'h0;
      fl_n_q   <= 4'h0;
      fl_tgt_q <= 4'h0;
    end else begin
      fl_tk_q <= fl_done ? 4'h0 : (tick ? fl_tk_q + 4'h1 : fl_tk_q);
      unique case (fl_q)
        FL_IDLE: begin
          fl_tk_q <= 4'h0;
          if (fl_want != 4'h0) begin
            fl_q     <= FL_ON;
            fl_tgt_q <= fl_want;
            fl_n_q   <= 4'h0;
          end
        end
        FL_ON: begin
          if (fl_done) begin
            fl_q   <= FL_OFF;
            fl_n_q <= fl_n_q + 4'h1;
          end
        end
        FL_OFF: begin
          if (fl_done) begin
            fl_q <= (fl_n_q == fl_tgt_q) ? FL_GAP : FL_ON;
          end
        end
        FL_GAP: begin
          if (fl_done) begin
            fl_q <= FL_IDLE;
          end
        end
      endcase
      if (fl_want == 4'h0) begin
        fl_q <= FL_IDLE;  // condition gone, stop at once
      end
    end
  end

  // ---------------- power removal latch ----------------
  // held past release until the clear input; a new removal wins
  logic pr_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pr_q <= 1'b0;
    end else if (i_cond.power_removal) begin
      pr_q <= 1'b1;
    end else if (i_cond.torque_off_clear) begin
      pr_q <= 1'b0;
    end
  end

  // ---------------- interlock release countdown ----------------
  logic [7:0] il_q;  // ticks left
  wire        il_on = (il_q != 8'h00);
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      il_q <= 8'h00;
    end else if (i_cond.interlock_released) begin
      il_q <= il_dur;
    end else if (tick && il_on) begin
      il_q <= il_q - 8'h01;
    end
  end

  // ---------------- lamp selection, highest priority first ----------
  sli_pkg::sli_pair_t pa_sel;
  sli_pkg::sli_pair_t ms_sel;
  sli_pkg::sli_pair_t ns_sel;
  logic               link_sel;
  wire                pwr = i_cond.ctrl_power;
  wire                sim_g = (sim_q == SM_GREEN) || (sim_q == SM_BOTH);
  wire                sim_r = (sim_q == SM_RED) || (sim_q == SM_BOTH);

  // power and alarm lamp
  assign pa_sel =
    !pwr                ? 2'b00 :
    i_cond.sim_mode     ? {sim_g, sim_r} :
    i_cond.alarm        ? {1'b0, fl_lit} :
    pr_q                ? {blink_q, 1'b0} :
    (i_cond.info || i_cond.support_op) ?
                          {fl_lit, fl_lit} :
    i_cond.origin_busy  ? 2'b11 :
    il_on               ? {blink_q, blink_q} :
                          2'b10;

  // module status lamp
  assign ms_sel =
    !pwr                ? 2'b00 :
    i_cond.self_diag    ? {blink_q, ~blink_q} :
    i_cond.alarm_fatal  ? 2'b01 :
    (i_cond.alarm || i_cond.dup_ip) ?
                          {1'b0, blink_q} :
    i_cond.cfg_invalid  ? {blink_q, 1'b0} :
                          2'b10;

  // network status lamp
  assign ns_sel =
    !pwr                ? 2'b00 :
    i_cond.self_diag    ? {blink_q, ~blink_q} :
    i_cond.dup_ip       ? 2'b01 :
    i_cond.conn_timeout ? {1'b0, blink_q} :
    !i_cond.online      ? 2'b00 :
    i_cond.scanner_conn ? 2'b10 :
                          {blink_q, 1'b0};

  // link lamp
  assign link_sel = pwr && i_cond.online &&
                    (i_cond.frame_activity ? fast_q : 1'b1);

  // status readback
  assign status_word = {18'h0, il_on, pr_q, fl_q, sim_q, 1'b0, o_lamps};

  // registered lamp and interrupt outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_lamps <= '0;
      o_irq   <= 1'b0;
    end else begin
      o_lamps <= lamp_en ? {pa_sel, ms_sel, ns_sel, link_sel} : '0;
      o_irq   <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_removal_released;
    i_cond.power_removal ##1 !i_cond.power_removal && !i_cond.torque_off_clear;
  endsequence
  sequence s_stable_en;
    lamp_en && $stable(lamp_en);
  endsequence

  AST_PA_DARK: assert property (
    !pwr && lamp_en |=> !o_lamps.pa_green && !o_lamps.pa_red)
    else $error("power lamp lit without control power");
  AST_PA_GREEN: assert property (
    s_stable_en and (pwr && !i_cond.sim_mode && !i_cond.alarm && !pr_q &&
    fl_want == 4'h0 && !i_cond.origin_busy && !il_on)
    |=> o_lamps.pa_green && !o_lamps.pa_red)
    else $error("power lamp not steady green when idle");
  AST_ALARM_NO_GREEN: assert property (
    lamp_en && pwr && i_cond.alarm && !i_cond.sim_mode
    |=> !o_lamps.pa_green)
    else $error("green lit during alarm");
  AST_PR_HOLD: assert property (
    s_removal_released ##0 !i_cond.torque_off_clear[*1] |=> pr_q)
    else $error("power removal latch dropped without clear");
  AST_INTERLOCK_LOAD: assert property (
    i_cond.interlock_released |=> il_q == $past(il_dur))
    else $error("interlock countdown not loaded");
  AST_ORIGIN_BOTH: assert property (
    s_stable_en and (pwr && i_cond.origin_busy && !i_cond.sim_mode &&
    !i_cond.alarm && !pr_q && fl_want == 4'h0)
    |=> o_lamps.pa_green && o_lamps.pa_red)
    else $error("origin function not shown as both lit");
  AST_MS_FATAL: assert property (
    lamp_en && pwr && !i_cond.self_diag && i_cond.alarm_fatal
    |=> !o_lamps.ms_green && o_lamps.ms_red)
    else $error("fatal alarm not steady red");
  AST_DIAG_ALT: assert property (
    lamp_en && pwr && i_cond.self_diag
    |=> o_lamps.ms_green != o_lamps.ms_red &&
        o_lamps.ns_green != o_lamps.ns_red)
    else $error("self-diagnosis colours not alternating");
  AST_BLINK_HALF: assert property (
    tick && bl_cnt_q == sli_pkg::BLINK_HALF_TICKS - 4'h1
    |=> blink_q != $past(blink_q))
    else $error("blink half not 500 ms");
  AST_NS_DUP: assert property (
    lamp_en && pwr && !i_cond.self_diag && i_cond.dup_ip
    |=> !o_lamps.ns_green && o_lamps.ns_red)
    else $error("duplicate address not steady red");
  AST_LINK_IDLE: assert property (
    lamp_en && pwr && i_cond.online && !i_cond.frame_activity
    |=> o_lamps.link)
    else $error("link lamp dark while online and idle");
  AST_IRQ_STICKY: assert property (
    irq_set != 5'h00 |=> (irq_stat_q & $past(irq_set)) == $past(irq_set))
    else $error("event lost from status");
endmodule : sli_top
`default_nettype wire

// ---- testbench/sli_lamp_viewer.sv ----
// Purpose: operator eye on the lamps, measures how long each stays lit
// Assumes: lamps sampled on every rising clock edge
// Notes:   reports the length of the last completed lit run per lamp
`default_nettype none
module sli_lamp_viewer (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire sli_pkg::sli_lamps_t i_lamps,
  output var  logic [15:0]         o_on_len [7]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_q [7]; // cycles lit so far, per lamp

  // a run is only reported once it ends, so partial runs never show
  always_ff @(posedge i_ref_clk) begin
    for (int b = 0; b < 7; b++) begin
      if (i_rst) begin
        run_q[b]    <= 16'h0000;
        o_on_len[b] <= 16'h0000;
      end else if (i_lamps[b]) begin
        run_q[b] <= run_q[b] + 16'h0001;
      end else begin
        if (run_q[b] != 16'h0000) o_on_len[b] <= run_q[b];
        run_q[b] <= 16'h0000;
      end
    end
  end
endmodule // sli_lamp_viewer
`default_nettype wire

// ---- testbench/sli_top_tb.sv ----
// Purpose: self-checking bench of the front-panel lamp logic
// Assumes: short base tick of 4 clocks, so blink half is 20 clocks
// Notes:   lamps judged over windows; bus driven as an Avalon master
`default_nettype none
module sli_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;        // clocks per base tick
  localparam int HALF = TICK * 5; // clocks per blink half
  localparam int N    = 128;      // watch window in clocks
  localparam int PG = 6, PR = 5, MG = 4, MR = 3, NG = 2, NR = 1, LK = 0;
  logic                i_ref_clk = 1'b0;
  logic                i_rst     = 1'b1;
  sli_pkg::sli_cond_t  cond      = '0;   // driven conditions
  sli_pkg::sli_cond_t  c         = '0;   // conditions being prepared
  logic [3:0]          adr       = 4'h0;
  logic                rd        = 1'b0;
  logic                wr        = 1'b0;
  logic [31:0]         wd        = 32'h0000_0000;
  logic [31:0]         q;
  logic [31:0]         rdata;
  logic                wreq;
  sli_pkg::sli_lamps_t lamps;
  logic                irq;
  logic [15:0]         on_len [7];
  int                  lit [7];          // cycles lit in window
  int                  rs [7];           // rises in window
  int                  err_count  = 0;
  int                  num_checks = 0;
  int                  cyc        = 0;

  always #25 i_ref_clk = ~i_ref_clk; // 20 MHz

  sli_top #(.TICK_CYCLES(TICK)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cond(cond),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_lamps(lamps), .o_irq(irq));
  sli_lamp_viewer i_view (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_lamps(lamps),
    .o_on_len(on_len));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // one Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge i_ref_clk);
    adr <= a;
    rd  <= ~w;
    wr  <= w;
    wd  <= d;
    do @(posedge i_ref_clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // present prepared conditions and let the lamps settle
  task automatic apply();
    @(posedge i_ref_clk);
    cond <= c;
    repeat (3) @(posedge i_ref_clk);
  endtask

  // count lit cycles and rises of every lamp over n clocks
  task automatic watch(input int n);
    sli_pkg::sli_lamps_t prev;
    prev = lamps;
    for (int b = 0; b < 7; b++) begin
      lit[b] = 0;
      rs[b]  = 0;
    end
    repeat (n) begin
      @(posedge i_ref_clk);
      for (int b = 0; b < 7; b++) begin
        lit[b] += int'(lamps[b]);
        rs[b]  += int'(lamps[b] & ~prev[b]);
      end
      prev = lamps;
    end
  endtask

  // power off is dark, power on shows idle green; control register at reset, unmapped offset reads zero
  task automatic t_power();
    apply();
    chk(32'(lamps), 32'h0000_0000);
    c.ctrl_power = 1'b1;
    apply();
    watch(N);
    chk(lit[PG], N);
    chk(lit[PR] + lit[MR], 0);
    chk(lit[MG], N);
    chk(lit[NG] + lit[NR] + lit[LK], 0);
    bus(1'b0, sli_pkg::OFS_CTRL, 32'h0000_0000);
    chk(q, sli_pkg::CTRL_RST);
    bus(1'b0, 4'h1, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask

  // alarm flashing, module lamp red, interrupt set and cleared
  task automatic t_alarm();
    bus(1'b1, sli_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    c.alarm      = 1'b1;
    c.alarm_code = 4'h3;
    apply();
    chk(32'(irq), 32'h0000_0001);
    watch(N);
    chk(lit[PG] + lit[MG], 0);
    chk(32'(rs[PR] >= 3), 32'h0000_0001);
    chk(32'(rs[MR] >= 2), 32'h0000_0001);
    bus(1'b1, sli_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge i_ref_clk);
    chk(32'(irq), 32'h0000_0000);
    c.alarm_fatal = 1'b1;
    apply();
    watch(N);
    chk(lit[MR], N);
    c.self_diag = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[MG] >= 2 && rs[MR] >= 2), 32'h0000_0001);
    chk(32'(rs[NG] >= 2 && rs[NR] >= 2), 32'h0000_0001);
    c.self_diag   = 1'b0;
    c.alarm       = 1'b0;
    c.alarm_fatal = 1'b0;
    apply();
    watch(N);
    chk(lit[PG], N);
  endtask

  // network and link lamps, masked events still latch in status
  task automatic t_net();
    c.online = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[NG] >= 2), 32'h0000_0001);
    chk(32'(on_len[NG]), HALF);
    chk(lit[LK], N);
    c.scanner_conn   = 1'b1;
    c.frame_activity = 1'b1;
    apply();
    watch(N);
    chk(lit[NG], N);
    chk(32'(on_len[LK]), TICK);
    c.scanner_conn = 1'b0;
    c.conn_timeout = 1'b1;
    apply();
    watch(N);
    chk(lit[NG], 0);
    chk(32'(rs[NR] >= 2), 32'h0000_0001);
    c.dup_ip = 1'b1;
    apply();
    watch(N);
    chk(lit[NR], N);
    chk(32'(rs[MR] >= 2), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b0, sli_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk(q, 32'h0000_001C);
    c = '0;
    c.ctrl_power = 1'b1;
    apply();
  endtask

  // power removal latch, information, origin button and simulation
  task automatic t_pa();
    c.power_removal = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[PG] >= 2 && lit[PR] == 0), 32'h0000_0001);
    c.power_removal = 1'b0;
    apply();
    watch(N);
    chk(32'(rs[PG] >= 2), 32'h0000_0001);
    c.torque_off_clear = 1'b1;
    apply();
    c.torque_off_clear = 1'b0;
    apply();
    watch(N);
    chk(lit[PG], N);
    c.info = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[PG] >= 2 && rs[PG] == rs[PR]), 32'h0000_0001);
    c.info        = 1'b0;
    c.origin_busy = 1'b1;
    apply();
    watch(N);
    chk(lit[PG] + lit[PR], 2 * N);
    c.origin_busy = 1'b0;
    c.sim_mode    = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[PG] >= 1 && rs[PR] >= 1), 32'h0000_0001);
  endtask

  // bad setting, support operation, interlock release, lamp enable
  task automatic t_misc();
    c = '0;
    c.ctrl_power  = 1'b1;
    c.cfg_invalid = 1'b1;
    c.support_op  = 1'b1;
    apply();
    watch(N);
    chk(32'(rs[MG] >= 2 && lit[MR] == 0), 32'h0000_0001);
    chk(32'(rs[PG] >= 2 && rs[PG] == rs[PR]), 32'h0000_0001);
    c.cfg_invalid = 1'b0;
    c.support_op  = 1'b0;
    apply();
    // one-cycle release pulse, countdown of 10 ticks from reset value
    c.interlock_released = 1'b1;
    @(posedge i_ref_clk);
    cond <= c;
    c.interlock_released = 1'b0;
    @(posedge i_ref_clk);
    cond <= c;
    @(posedge i_ref_clk);
    watch(32);
    chk(32'(lit[PG] == lit[PR] && lit[PR] > 0), 32'h0000_0001);
    watch(16);
    watch(N);
    chk(lit[PG], N);
    chk(lit[PR], 0);
    // clearing the enable bit blanks every lamp
    bus(1'b1, sli_pkg::OFS_CTRL, 32'h0000_000A);
    repeat (2) @(posedge i_ref_clk);
    chk(32'(lamps), 32'h0000_0000);
    bus(1'b0, sli_pkg::OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_000A);
    bus(1'b1, sli_pkg::OFS_CTRL, sli_pkg::CTRL_RST);
  endtask

  // verdict in one place
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_power();
    t_alarm();
    t_net();
    t_pa();
    t_misc();
    final_report();
  end
endmodule // sli_top_tb
`default_nettype wire
